/* hdl/interval_timer.v */
// Purpose: three channel programmable interval timer behind an 8-bit port
// Assumes: all pins synchronous to clock; count clocks much slower
// Notes: count clock edges are found by sampling, so each count clock
//        level must last at least one system clock period
`include "interval_timer_consts.vh"
`default_nettype none

// What this block does
// - Three independent 16-bit down counters with clock, gate and out.
// - Each counter decrements in binary or BCD as its configuration selects.
// - Bus access only with device select low; select never affects counting.
// - Port select 0..2 picks a counter, 3 picks the configuration word.
// - Data port undriven unless selected read of a counter port.
// - Configuration word is write-only; reading it drives nothing.
// - Counters act on the falling edge of their own count clock.
// - A capture freezes a copy for reading while counting continues.
// - Mode 0: out low after setup and load, high at terminal count.
// - Mode 0: counter keeps decrementing past terminal count without reload.
// - Mode 0: first byte of a new count halts, second byte restarts.
// - Mode 1: out falls on clock after gate rise, rises at terminal count.
// - Mode 1: every gate rise retriggers the full count.
// - Mode 1: new count waits for next trigger; reads never disturb pulse.
// - Mode 2: divide by N, out low one clock per N clocks.
// - Mode 2: a reload sets the next period, not the present one.
// - Mode 2: low gate forces out high; gate rise restarts from count.
// - Mode 2: out stays high after setup until a count is loaded.
// - Mode 3: decrement by two, toggle and reload at terminal count.
// - Mode 3: odd N steps 1 first while high, 3 first while low.
// - Mode 4: out high, count after load, one-clock low strobe at terminal.
// - Mode 4: low gate suspends counting; reload restarts from new value.
// - Mode 5: gate rise starts full count; one-clock low strobe at terminal.
// - Gate rise triggers modes 1,5, restarts modes 2,3; low gate stops others.
// - A written count enters the counter after a clock rise then fall.
// - A count of zero means 2^16 binary or 10^4 BCD.
// - Two-byte format: low byte first then high byte, for reads and writes.
module interval_timer #(
    parameter NUM_CH = 3,
    parameter CNT_W = 16
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // host port
    input wire csN,
    input wire rdN,
    input wire wrN,
    input wire portSelectLsb,
    input wire portSelectMsb,
    input wire [7:0] dataIn,
    output wire [7:0] dataOut,
    output wire dataOe,
    // counter pins
    input wire [NUM_CH-1:0] countClk,
    input wire [NUM_CH-1:0] gate,
    output wire [NUM_CH-1:0] timerOut
);

    wire [1:0] portSel = {portSelectMsb, portSelectLsb};
    wire rdAct = !csN && !rdN && wrN;
    reg wrPrev_ff;
    reg rdAct_ff;
    reg [1:0] rdSel_ff;
    reg [7:0] dataOut_ff;
    wire [8*NUM_CH-1:0] rdBytes;
    wire [NUM_CH-1:0] outs;

    // write taken once, on the first cycle the strobe is seen low
    wire wrTake = !csN && !wrN && rdN && wrPrev_ff;
    // a read byte is consumed when the read strobe ends
    wire rdEnd = rdAct_ff && !rdAct;

    assign dataOe = rdAct && (portSel != `SEL_CTRL);
    assign dataOut = dataOut_ff;
    assign timerOut = outs;

    always @(posedge clock) begin
        if (!rst_n) begin
            wrPrev_ff <= 1'b1;
            rdAct_ff <= 1'b0;
            rdSel_ff <= 2'h0;
            dataOut_ff <= `BYTE_ZERO;
        end else begin
            wrPrev_ff <= wrN || csN;
            rdAct_ff <= rdAct;
            if (rdAct) begin
                rdSel_ff <= portSel;
            end
            if (portSel != `SEL_CTRL) begin
                dataOut_ff <= rdBytes[8*portSel +: 8];
            end else begin
                dataOut_ff <= `BYTE_ZERO;
            end
        end
    end

    function [15:0] decOne;
        input [15:0] v;
        input b;
        integer k;
        reg borrow;
        reg [15:0] r;
        begin
            r = v;
            borrow = 1'b1;
            if (!b) begin
                r = v - `CNT_ONE;
            end else begin
                for (k = 0; k < 4; k = k + 1) begin
                    if (borrow) begin
                        if (r[4*k +: 4] == 4'h0) begin
                            r[4*k +: 4] = 4'h9;
                        end else begin
                            r[4*k +: 4] = r[4*k +: 4] - 4'h1;
                            borrow = 1'b0;
                        end
                    end
                end
            end
            decOne = r;
        end
    endfunction

    // zero wraps to all nines or all ones, giving the maximum count
    function [15:0] decStep;
        input [15:0] v;
        input [1:0] s;
        input b;
        reg [15:0] r;
        begin
            r = decOne(v, b);
            if (s != `STEP_ONE) begin
                r = decOne(r, b);
            end
            if (s == `STEP_THREE) begin
                r = decOne(r, b);
            end
            decStep = r;
        end
    endfunction

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : chan
            reg [2:0] mode_ff;
            reg [1:0] fmt_ff;
            reg bcd_ff;
            reg [CNT_W-1:0] hold_ff;
            reg [CNT_W-1:0] init_ff;
            reg [CNT_W-1:0] cnt_ff;
            reg [CNT_W-1:0] latVal_ff;
            reg out_ff;
            reg pend_ff;
            reg rise_ff;
            reg wPtr_ff;
            reg rPtr_ff;
            reg lat_ff;
            reg run_ff;
            reg armed_ff;
            reg trig_ff;
            reg gPrev_ff;
            reg cPrev_ff;
            reg first_ff;
            reg fired_ff;

            wire tick = cPrev_ff && !countClk[i];
            wire clkRise = !cPrev_ff && countClk[i];
            wire gRise = !gPrev_ff && gate[i];
            wire trigNow = trig_ff || gRise;
            wire loadNow = tick && pend_ff && rise_ff;
            wire [CNT_W-1:0] initEff = loadNow ? hold_ff : init_ff;
            wire selW = wrTake && (portSel == i);
            wire ctrlW = wrTake && (portSel == `SEL_CTRL) &&
                (dataIn[`CW_SC_HI:`CW_SC_LO] == i);
            wire [1:0] cwFmt = dataIn[`CW_FMT_HI:`CW_FMT_LO];
            wire [2:0] cwMode = dataIn[`CW_MODE_HI:`CW_MODE_LO];
            wire [1:0] step = (first_ff && init_ff[0]) ?
                (out_ff ? `STEP_ONE : `STEP_THREE) : `STEP_TWO;
            wire [CNT_W-1:0] val = lat_ff ? latVal_ff : cnt_ff;
            wire hiByte = (fmt_ff == `FMT_MSB) ||
                ((fmt_ff == `FMT_BOTH) && rPtr_ff);

            assign rdBytes[8*i +: 8] = hiByte ? val[15:8] : val[7:0];
            assign outs[i] = out_ff;

            always @(posedge clock) begin
                if (!rst_n) begin
                    mode_ff <= `MODE_TCINT;
                    fmt_ff <= `FMT_BOTH;
                    bcd_ff <= 1'b0;
                    hold_ff <= 16'h0000;
                    init_ff <= 16'h0000;
                    cnt_ff <= 16'h0000;
                    latVal_ff <= 16'h0000;
                    out_ff <= 1'b0;
                    pend_ff <= 1'b0;
                    rise_ff <= 1'b0;
                    wPtr_ff <= 1'b0;
                    rPtr_ff <= 1'b0;
                    lat_ff <= 1'b0;
                    run_ff <= 1'b0;
                    armed_ff <= 1'b0;
                    trig_ff <= 1'b0;
                    // a gate already high after reset is not a trigger
                    gPrev_ff <= 1'b1;
                    cPrev_ff <= 1'b0;
                    first_ff <= 1'b0;
                    fired_ff <= 1'b1;
                end else begin
                    cPrev_ff <= countClk[i];
                    gPrev_ff <= gate[i];
                    // gate edges wait for the next count clock fall
                    trig_ff <= tick ? 1'b0 : trigNow;
                    if (clkRise && pend_ff) begin
                        rise_ff <= 1'b1;
                    end

                    if (tick) begin
                        case (mode_ff)
                        `MODE_TCINT: begin
                            if (loadNow) begin
                                cnt_ff <= hold_ff;
                                run_ff <= 1'b1;
                                out_ff <= 1'b0;
                            end else if (run_ff && gate[i]) begin
                                cnt_ff <= decStep(cnt_ff, `STEP_ONE,
                                    bcd_ff);
                                if (cnt_ff == `CNT_ONE) begin
                                    out_ff <= 1'b1;
                                end
                            end
                        end
                        `MODE_ONESHOT: begin
                            if (trigNow && (armed_ff || loadNow)) begin
                                cnt_ff <= initEff;
                                out_ff <= 1'b0;
                                fired_ff <= 1'b0;
                            end else begin
                                cnt_ff <= decStep(cnt_ff, `STEP_ONE,
                                    bcd_ff);
                                if (cnt_ff == `CNT_ONE && !fired_ff) begin
                                    out_ff <= 1'b1;
                                    fired_ff <= 1'b1;
                                end
                            end
                        end
                        `MODE_RATE: begin
                            if (!gate[i]) begin
                                out_ff <= 1'b1;
                            end else if (trigNow ||
                                (loadNow && !armed_ff)) begin
                                cnt_ff <= initEff;
                                out_ff <= 1'b1;
                            end else if (armed_ff) begin
                                if (cnt_ff == `CNT_ONE) begin
                                    cnt_ff <= initEff;
                                    out_ff <= 1'b1;
                                end else begin
                                    cnt_ff <= decStep(cnt_ff, `STEP_ONE,
                                        bcd_ff);
                                    out_ff <= (cnt_ff != `CNT_TWO);
                                end
                            end
                        end
                        `MODE_SQUARE: begin
                            if (!gate[i]) begin
                                out_ff <= 1'b1;
                            end else if (trigNow ||
                                (loadNow && !armed_ff)) begin
                                cnt_ff <= initEff;
                                out_ff <= 1'b1;
                                first_ff <= 1'b1;
                            end else if (armed_ff) begin
                                if (cnt_ff == {14'h0000, step}) begin
                                    out_ff <= !out_ff;
                                    cnt_ff <= initEff;
                                    first_ff <= 1'b1;
                                end else begin
                                    cnt_ff <= decStep(cnt_ff, step,
                                        bcd_ff);
                                    first_ff <= 1'b0;
                                end
                            end
                        end
                        `MODE_SWSTROBE, `MODE_HWSTROBE: begin
                            if ((mode_ff == `MODE_SWSTROBE) ? loadNow :
                                (trigNow && (armed_ff || loadNow))) begin
                                cnt_ff <= initEff;
                                run_ff <= 1'b1;
                                out_ff <= 1'b1;
                                fired_ff <= 1'b0;
                            end else if (run_ff && (gate[i] ||
                                mode_ff == `MODE_HWSTROBE)) begin
                                cnt_ff <= decStep(cnt_ff, `STEP_ONE,
                                    bcd_ff);
                                // strobe only once per load in mode 4, or once per trigger in mode 5
                                out_ff <= !(cnt_ff == `CNT_ONE &&
                                    !fired_ff);
                                if (cnt_ff == `CNT_ONE) begin
                                    fired_ff <= 1'b1;
                                end
                            end
                        end
                        default: begin
                            out_ff <= 1'b1;
                        end
                        endcase
                        if (loadNow) begin
                            init_ff <= hold_ff;
                            armed_ff <= 1'b1;
                            pend_ff <= 1'b0;
                            rise_ff <= 1'b0;
                        end
                    end

                    // reads: capture stays until every byte is taken
                    if (rdEnd && rdSel_ff == i) begin
                        if (fmt_ff == `FMT_BOTH) begin
                            rPtr_ff <= !rPtr_ff;
                        end
                        if (fmt_ff != `FMT_BOTH || rPtr_ff) begin
                            lat_ff <= 1'b0;
                        end
                    end

                    // host writes come last so they win over counting
                    if (ctrlW) begin
                        if (cwFmt == `FMT_LATCH) begin
                            if (!lat_ff) begin
                                latVal_ff <= cnt_ff;
                                lat_ff <= 1'b1;
                            end
                        end else begin
                            mode_ff <= (cwMode[1:0] == `MODE_ALIAS_HI) ?
                                {1'b0, cwMode[1:0]} : cwMode;
                            fmt_ff <= cwFmt;
                            bcd_ff <= dataIn[`CW_BCD];
                            out_ff <= (cwMode != `MODE_TCINT);
                            run_ff <= 1'b0;
                            armed_ff <= 1'b0;
                            pend_ff <= 1'b0;
                            rise_ff <= 1'b0;
                            wPtr_ff <= 1'b0;
                            rPtr_ff <= 1'b0;
                            lat_ff <= 1'b0;
                            fired_ff <= 1'b1;
                        end
                    end else if (selW) begin
                        rise_ff <= 1'b0;
                        case (fmt_ff)
                        `FMT_LSB: begin
                            hold_ff <= {`BYTE_ZERO, dataIn};
                            pend_ff <= 1'b1;
                        end
                        `FMT_MSB: begin
                            hold_ff <= {dataIn, `BYTE_ZERO};
                            pend_ff <= 1'b1;
                        end
                        default: begin
                            if (!wPtr_ff) begin
                                hold_ff[7:0] <= dataIn;
                                wPtr_ff <= 1'b1;
                                pend_ff <= 1'b0;
                                if (mode_ff == `MODE_TCINT) begin
                                    run_ff <= 1'b0;
                                end
                            end else begin
                                hold_ff[15:8] <= dataIn;
                                wPtr_ff <= 1'b0;
                                pend_ff <= 1'b1;
                            end
                        end
                        endcase
                    end
                end
            end
        end
    endgenerate

endmodule // interval_timer

`default_nettype wire

/* hdl/interval_timer_consts.vh */
// Purpose: named constants of the three channel interval timer
// Assumes: included by bare name from the timer design file
// Notes: definitions only
`ifndef INTERVAL_TIMER_CONSTS_VH
`define INTERVAL_TIMER_CONSTS_VH

// port-select codes
`define SEL_CTRL 2'h3

// configuration word fields
`define CW_SC_HI 7
`define CW_SC_LO 6
`define CW_FMT_HI 5
`define CW_FMT_LO 4
`define CW_MODE_HI 3
`define CW_MODE_LO 1
`define CW_BCD 0

// byte format codes
`define FMT_LATCH 2'h0
`define FMT_LSB 2'h1
`define FMT_MSB 2'h2
`define FMT_BOTH 2'h3

// operating modes
`define MODE_TCINT 3'h0
`define MODE_ONESHOT 3'h1
`define MODE_RATE 3'h2
`define MODE_SQUARE 3'h3
`define MODE_SWSTROBE 3'h4
`define MODE_HWSTROBE 3'h5
`define MODE_ALIAS_HI 2'h3

// count values and decrement steps
`define CNT_ONE 16'h0001
`define CNT_TWO 16'h0002
`define STEP_ONE 2'h1
`define STEP_TWO 2'h2
`define STEP_THREE 2'h3
`define BYTE_ZERO 8'h00

`endif

/* bench/interval_timer_checker.sv */
// Purpose: port-level assertions for the interval timer
// Assumes: bound to interval_timer; one clock domain
// Notes: timer outputs may move only after a sampled tick or a host write
`default_nettype none
module interval_timer_checker #(
    parameter NUM_CH = 3,
    parameter CNT_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // host port
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic portSelectLsb,
    input wire logic portSelectMsb,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    // counter pins
    input wire logic [NUM_CH-1:0] countClk,
    input wire logic [NUM_CH-1:0] gate,
    input wire logic [NUM_CH-1:0] timerOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic sel3 = portSelectMsb & portSelectLsb;
    sequence rdAct;
        !csN && !rdN && wrN && !sel3;
    endsequence
    // gate edges wait for a tick, so every channel obeys this
    property outTick(int i);
        $changed(timerOut[i]) |->
            ($past(countClk[i], 2) && !$past(countClk[i]))
            || ($past(countClk[i], 3) && !$past(countClk[i], 2))
            || !$past(wrN) || !$past(wrN, 2);
    endproperty
    oe_idle_a: assert property (csN |-> !dataOe)
        else $error("data port driven while deselected");
    oe_ctrl_a: assert property (sel3 |-> !dataOe)
        else $error("configuration word was driven out");
    oe_read_a: assert property (rdAct |-> dataOe)
        else $error("selected counter read not driven");
    oe_write_a: assert property (!wrN |-> !dataOe)
        else $error("data port driven during write");
    oe_hold_a: assert property (
        rdAct ##1 rdAct |-> dataOe && $past(dataOe))
        else $error("read drive dropped mid strobe");
    oe_drop_a: assert property ($rose(rdN) |-> !dataOe)
        else $error("data port held after read strobe");
    out0_tick_a: assert property (outTick(0))
        else $error("channel 0 output moved without a tick");
    out2_tick_a: assert property (outTick(2))
        else $error("channel 2 output moved without a tick");
    out1_tick_a: assert property (outTick(1))
        else $error("channel 1 output moved without a tick");
endmodule // interval_timer_checker
bind interval_timer interval_timer_checker #(.NUM_CH(NUM_CH), .CNT_W(CNT_W))
    i_interval_timer_checker (.clock(clock), .rst_n(rst_n), .csN(csN),
    .rdN(rdN), .wrN(wrN), .portSelectLsb(portSelectLsb),
    .portSelectMsb(portSelectMsb), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .countClk(countClk), .gate(gate),
    .timerOut(timerOut));
`default_nettype wire

/* bench/host_bus_model.sv */
// Purpose: host processor side of the timer's 8-bit port
// Assumes: driven from the system clock edge
// Notes: idle write data shows the inverse of the last byte sent
`default_nettype none
module host_bus_model (
    // clock and bus outputs
    input wire logic clock,
    output logic csN,
    output logic rdN,
    output logic wrN,
    output logic portSelectLsb,
    output logic portSelectMsb,
    output logic [7:0] dataIn,
    // read return
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {csN, rdN, wrN} = 3'h7;
        {portSelectMsb, portSelectLsb} = 2'h0;
        dataIn = 8'h00;
    end
    // strobe held two cycles, then two idle cycles before the next
    task automatic busWrite(input logic [1:0] sel, input logic [7:0] d,
        input logic cs);
        @(posedge clock);
        {portSelectMsb, portSelectLsb} <= sel;
        dataIn <= d;
        csN <= !cs;
        wrN <= 1'b0;
        repeat (2) @(posedge clock);
        {csN, wrN} <= 2'h3;
        dataIn <= ~d;
        @(posedge clock);
    endtask
    task automatic busRead(input logic [1:0] sel, output logic [7:0] d,
        output logic oe);
        @(posedge clock);
        {portSelectMsb, portSelectLsb} <= sel;
        {csN, rdN} <= 2'h0;
        repeat (2) @(posedge clock);
        d = dataOut;
        oe = dataOe;
        {csN, rdN} <= 2'h3;
        @(posedge clock);
    endtask
endmodule // host_bus_model
`default_nettype wire

/* bench/tb_interval_timer.sv */
// Purpose: self-checking bench for the interval timer
// Assumes: count clocks made by hand, seven system clocks a period
// Notes: channel 0 also carries the one-shot, strobe and decimal cases
`default_nettype none
module tb_interval_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, csN, rdN, wrN, portSelectLsb, portSelectMsb, dataOe;
    logic [7:0] dataIn, dataOut, d;
    logic [2:0] countClk, gate, timerOut;
    logic [15:0] v;
    logic oe;
    int fails, checked, cycles, lows;
    interval_timer i_interval_timer (.clock(clock), .rst_n(rst_n),
        .csN(csN), .rdN(rdN), .wrN(wrN), .portSelectLsb(portSelectLsb),
        .portSelectMsb(portSelectMsb), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .countClk(countClk), .gate(gate),
        .timerOut(timerOut));
    host_bus_model i_host_bus_model (.clock(clock), .csN(csN), .rdN(rdN),
        .wrN(wrN), .portSelectLsb(portSelectLsb),
        .portSelectMsb(portSelectMsb), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic ticks(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge clock);
            countClk <= countClk | m;
            repeat (3) @(posedge clock);
            countClk <= countClk & ~m;
            repeat (3) @(posedge clock);
        end
    endtask
    // gate low across one tick, high again just after it
    task automatic pulse(input logic [2:0] m);
        gate <= gate & ~m;
        ticks(m, 1);
        gate <= gate | m;
    endtask
    task automatic cw(input logic [7:0] w);
        i_host_bus_model.busWrite(2'h3, w, 1'b1);
    endtask
    task automatic wr16(input logic [1:0] ch, input logic [15:0] val);
        i_host_bus_model.busWrite(ch, val[7:0], 1'b1);
        i_host_bus_model.busWrite(ch, val[15:8], 1'b1);
    endtask
    task automatic rd16(input logic [1:0] ch, output logic [15:0] val);
        i_host_bus_model.busRead(ch, val[7:0], oe);
        i_host_bus_model.busRead(ch, val[15:8], oe);
    endtask
    task automatic test_mode0();
        cw(8'h30);
        chkBit(timerOut[0], 1'b0);
        wr16(2'h0, 16'h0003);
        ticks(3'h1, 3);
        chkBit(timerOut[0], 1'b0);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b1);
        ticks(3'h1, 2);
        cw(8'h00);
        ticks(3'h1, 2);
        cw(8'h00);
        rd16(2'h0, v);
        chk(v, 16'hfffe);
        i_host_bus_model.busWrite(2'h0, 8'h05, 1'b1);
        ticks(3'h1, 3);
        cw(8'h00);
        rd16(2'h0, v);
        chk(v, 16'hfffc);
        i_host_bus_model.busWrite(2'h0, 8'h00, 1'b1);
        ticks(3'h1, 5);
        chkBit(timerOut[0], 1'b0);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b1);
    endtask
    task automatic test_bus();
        i_host_bus_model.busRead(2'h3, d, oe);
        chkBit(oe, 1'b0);
        i_host_bus_model.busWrite(2'h3, 8'h30, 1'b0);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b1);
        i_host_bus_model.busRead(2'h0, d, oe);
        chkBit(oe, 1'b1);
    endtask
    task automatic test_trig();
        cw(8'h32);
        wr16(2'h0, 16'h0003);
        ticks(3'h1, 2);
        chkBit(timerOut[0], 1'b1);
        pulse(3'h1);
        ticks(3'h1, 2);
        chkBit(timerOut[0], 1'b0);
        pulse(3'h1);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b0);
        wr16(2'h0, 16'h0005);
        ticks(3'h1, 2);
        chkBit(timerOut[0], 1'b0);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b1);
        pulse(3'h1);
        ticks(3'h1, 5);
        chkBit(timerOut[0], 1'b0);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b1);
        cw(8'h3a);
        wr16(2'h0, 16'h0002);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b1);
        pulse(3'h1);
        ticks(3'h1, 3);
        chkBit(timerOut[0], 1'b0);
        ticks(3'h1, 1);
        chkBit(timerOut[0], 1'b1);
        pulse(3'h1);
        ticks(3'h1, 3);
        chkBit(timerOut[0], 1'b0);
        cw(8'h31);
        wr16(2'h0, 16'h0000);
        ticks(3'h1, 2);
        cw(8'h00);
        rd16(2'h0, v);
        chk(v, 16'h9999);
    endtask
    task automatic test_rate();
        cw(8'h74);
        ticks(3'h2, 3);
        chkBit(timerOut[1], 1'b1);
        wr16(2'h1, 16'h0003);
        ticks(3'h2, 3);
        chkBit(timerOut[1], 1'b0);
        ticks(3'h2, 1);
        chkBit(timerOut[1], 1'b1);
        wr16(2'h1, 16'h0002);
        ticks(3'h2, 2);
        chkBit(timerOut[1], 1'b0);
        ticks(3'h2, 2);
        chkBit(timerOut[1], 1'b0);
        gate[1] <= 1'b0;
        ticks(3'h2, 1);
        chkBit(timerOut[1], 1'b1);
        gate[1] <= 1'b1;
        ticks(3'h2, 2);
        chkBit(timerOut[1], 1'b0);
    endtask
    task automatic test_square();
        cw(8'hb6);
        wr16(2'h2, 16'h0005);
        ticks(3'h4, 1);
        lows = 0;
        for (int i = 0; i < 10; i++) begin
            ticks(3'h4, 1);
            lows += (timerOut[2] === 1'b0);
        end
        chk(lows[15:0], 16'h0004);
    endtask
    task automatic test_strobe();
        cw(8'hb8);
        chkBit(timerOut[2], 1'b1);
        wr16(2'h2, 16'h0003);
        ticks(3'h4, 1);
        gate[2] <= 1'b0;
        ticks(3'h4, 4);
        chkBit(timerOut[2], 1'b1);
        gate[2] <= 1'b1;
        ticks(3'h4, 2);
        chkBit(timerOut[2], 1'b1);
        ticks(3'h4, 1);
        chkBit(timerOut[2], 1'b0);
        ticks(3'h4, 1);
        chkBit(timerOut[2], 1'b1);
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        rst_n = 1'b0;
        countClk = 3'h0;
        gate = 3'h7;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        test_mode0();
        test_bus();
        test_trig();
        test_rate();
        test_square();
        test_strobe();
        summarize();
    end
endmodule // tb_interval_timer
`default_nettype wire
